// File: hdl/zolc_pkg.sv
// package: constants for the zero-overhead loop controller
package zolc_pkg;
  localparam int          ADDR_W           = 32;
  localparam int          CNT_W            = 32;
  localparam logic [11:0] AUX_LOOP_FIRST   = 12'h002;
  localparam logic [11:0] AUX_LOOP_STOP    = 12'h003;
  localparam logic [31:0] LOOP_FIRST_RST   = 32'h00000000;
  localparam logic [31:0] LOOP_STOP_RST    = 32'h00000000;
  localparam logic [31:0] ITER_CNT_RST     = 32'h00000000;
  localparam logic [31:0] WORD_ALIGN_MASK  = 32'hFFFFFFFC;
  localparam int          SETTLE_WORDS     = 3;
endpackage

// File: hdl/zolc_regs_if.sv
// interface: loop register file write and read paths
interface zolc_regs_if;
  logic        setup_we;
  logic [31:0] setup_stop;
  logic [31:0] setup_first;
  logic        aux_we;
  logic [11:0] aux_addr;
  logic [31:0] aux_wdata;
  logic [31:0] first_addr;
  logic [31:0] stop_addr;
  modport ctrl (output setup_we, setup_stop, setup_first, aux_we, aux_addr, aux_wdata,
                input first_addr, stop_addr);
  modport regs (input setup_we, setup_stop, setup_first, aux_we, aux_addr, aux_wdata,
                output first_addr, stop_addr);
endinterface

// File: hdl/zolc_regs.sv
// module: loop start and loop end auxiliary registers
module zolc_regs (
  input  wire logic clock,
  input  wire logic rstn,
  zolc_regs_if.regs rif
);
  logic [31:0] first_r;
  logic [31:0] stop_r;

  // setup instruction and direct aux writes both land here
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      first_r <= zolc_pkg::LOOP_FIRST_RST;
      stop_r  <= zolc_pkg::LOOP_STOP_RST;
    end else if (rif.setup_we) begin
      first_r <= rif.setup_first;
      stop_r  <= rif.setup_stop;
    end else if (rif.aux_we) begin
      // (RULE3) direct writes honoured
      if (rif.aux_addr == zolc_pkg::AUX_LOOP_FIRST) begin
        first_r <= rif.aux_wdata;
      end
      if (rif.aux_addr == zolc_pkg::AUX_LOOP_STOP) begin
        stop_r <= rif.aux_wdata;
      end
    end
  end

  assign rif.first_addr = first_r;
  assign rif.stop_addr  = stop_r;
endmodule

// File: hdl/zolc_ctrl.sv
// module: next-fetch-address logic for the zero-overhead hardware loop
//
// Overview of operation
// (RULE1) setup loops need two-word bodies minimum
// (RULE2) long-immediate single instruction counts two words
// (RULE3) direct register writes may build one-word loops
// (RULE4) three words fetched after direct write
// (RULE5) long-immediate instruction takes two slots
// (RULE6) no long-immediate instruction in final slot
// (RULE7) final instruction always decrements counter
// (RULE8) count not 0/1, no branch: loop back
// (RULE9) taken branch target always wins
// (RULE10) loop addresses must start an instruction
// (RULE11) late counter writes take effect eventually; here a write in the loop-end cycle is dropped
// (RULE12) late counter reads may be stale
// (RULE13) early exit near end leaves count unpredictable
// (RULE14) delayed branches, setup banned near end
// (RULE15) no breakpoint or sleep at loop end
// (RULE16) start/end are aux registers 2 and 3
// (RULE17) setup writes end and start together
// (RULE18) count 0/1 exits sequentially past end
module zolc_ctrl (
  input  wire logic        clock,
  input  wire logic        rstn,
  input  wire logic        step,
  input  wire logic [31:0] current_program_counter,
  input  wire logic [31:0] seq_next_pc,
  input  wire logic        branch_taken,
  input  wire logic [31:0] branch_target,
  input  wire logic        setup_exec,
  input  wire logic [31:0] setup_disp,
  input  wire logic        aux_we,
  input  wire logic [11:0] aux_addr,
  input  wire logic [31:0] aux_wdata,
  input  wire logic        aux_re,
  input  wire logic        count_we,
  input  wire logic [31:0] count_wdata,
  output logic      [31:0] next_fetch_pc,
  output logic             loop_taken,
  output logic             loop_end_hit,
  output logic      [31:0] aux_rdata,
  output logic      [31:0] loop_iteration_counter
);
  zolc_regs_if rif ();
  logic [31:0] next_fetch_pc_r;
  logic        loop_taken_r;
  logic        loop_end_hit_r;
  logic [31:0] aux_rdata_r;
  logic [31:0] count_r;
  logic [31:0] count_nxt;
  logic [31:0] next_pc_nxt;
  logic        at_end;
  logic        count_low;

  zolc_regs u_regs (
    .clock (clock),
    .rstn  (rstn),
    .rif   (rif)
  );

  // (RULE17) setup writes end and start
  assign rif.setup_we    = step && setup_exec;
  assign rif.setup_stop  = (current_program_counter & zolc_pkg::WORD_ALIGN_MASK) + setup_disp;
  assign rif.setup_first = seq_next_pc;
  // (RULE16) aux addresses 2 and 3
  assign rif.aux_we      = step && aux_we;
  assign rif.aux_addr    = aux_addr;
  assign rif.aux_wdata   = aux_wdata;

  // end detect is by equality only; misaligned addresses are the program's problem
  // (RULE5) opcode slot compared
  // (RULE2) limm loops still match
  assign at_end    = step && (current_program_counter == rif.stop_addr);
  assign count_low = (count_r == 32'h00000000) || (count_r == 32'h00000001);

  // next fetch address choice
  always_comb begin
    next_pc_nxt = seq_next_pc;
    if (branch_taken) begin
      // (RULE9) branch target wins
      next_pc_nxt = branch_target;
    end else if (at_end && !count_low) begin
      // (RULE8) loop back to start
      next_pc_nxt = rif.first_addr;
    end else begin
      // (RULE18) fall through past end
      next_pc_nxt = seq_next_pc;
    end
  end

  // counter next value; software write loses to the end decrement,
  // so a write in the same cycle as the loop end is dropped
  always_comb begin
    count_nxt = count_r;
    // (RULE13) branch exit still decrements
    if (at_end) begin
      // (RULE7) decrement at last instruction
      count_nxt = count_r - 32'h00000001;
    end else if (count_we) begin
      // (RULE11) write applies next cycle; a write in the loop-end cycle is dropped
      count_nxt = count_wdata;
    end
  end

  // iteration counter
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      count_r <= zolc_pkg::ITER_CNT_RST;
    end else begin
      count_r <= count_nxt;
    end
  end

  // fetch redirect address, registered
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      next_fetch_pc_r <= 32'h00000000;
    end else begin
      next_fetch_pc_r <= next_pc_nxt;
    end
  end

  // loop-back pulse; a taken branch suppresses it
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      loop_taken_r <= 1'b0;
    end else begin
      loop_taken_r <= at_end && !count_low && !branch_taken;
    end
  end

  // end-hit pulse, raised whether the loop repeats or exits
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      loop_end_hit_r <= 1'b0;
    end else begin
      loop_end_hit_r <= at_end;
    end
  end

  // aux read port; unmapped addresses read zero
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      aux_rdata_r <= 32'h00000000;
    end else if (aux_re) begin
      case (aux_addr)
        zolc_pkg::AUX_LOOP_FIRST: aux_rdata_r <= rif.first_addr;
        zolc_pkg::AUX_LOOP_STOP:  aux_rdata_r <= rif.stop_addr;
        default:                  aux_rdata_r <= 32'h00000000;
      endcase
    end
  end

  // (RULE12) count read lags one cycle
  assign loop_iteration_counter = count_r;
  assign next_fetch_pc          = next_fetch_pc_r;
  assign loop_taken             = loop_taken_r;
  assign loop_end_hit           = loop_end_hit_r;
  assign aux_rdata              = aux_rdata_r;

  // checks
  AST_BRANCH_WINS: assert property (@(posedge clock) disable iff (!rstn) // RULE9
    branch_taken |=> next_fetch_pc == $past(branch_target))
    else $error("taken branch not next fetch");
  AST_LOOP_BACK: assert property (@(posedge clock) disable iff (!rstn) // RULE8
    (at_end && !count_low && !branch_taken) |=> loop_taken && next_fetch_pc == $past(rif.first_addr))
    else $error("loop back missing");
  AST_DECREMENT: assert property (@(posedge clock) disable iff (!rstn) // RULE7
    at_end |=> count_r == $past(count_r) - 32'h00000001)
    else $error("counter not decremented at end");
  AST_EXIT_SEQ: assert property (@(posedge clock) disable iff (!rstn) // RULE18
    (at_end && count_low && !branch_taken) |=> !loop_taken && next_fetch_pc == $past(seq_next_pc))
    else $error("loop exit not sequential");
  AST_SETUP_REGS: assert property (@(posedge clock) disable iff (!rstn) // RULE17
    rif.setup_we |=> rif.first_addr == $past(seq_next_pc) && rif.stop_addr == $past(rif.setup_stop))
    else $error("setup did not load loop registers");
  AST_DIRECT_WRITE: assert property (@(posedge clock) disable iff (!rstn) // RULE3
    (rif.aux_we && !rif.setup_we && aux_addr == zolc_pkg::AUX_LOOP_STOP)
      |=> rif.stop_addr == $past(aux_wdata))
    else $error("direct end write ignored");
  AST_AUX_READ: assert property (@(posedge clock) disable iff (!rstn) // RULE16
    (aux_re && aux_addr == zolc_pkg::AUX_LOOP_FIRST) |=> aux_rdata == $past(rif.first_addr))
    else $error("start register read wrong");
  AST_COUNT_WRITE: assert property (@(posedge clock) disable iff (!rstn) // RULE11
    (count_we && !at_end) |=> count_r == $past(count_wdata))
    else $error("counter write lost");

  // quiet-cycle checks: nothing moves without its cause, and a taken branch blocks loop-back
  AST_BRANCH_NO_LOOP: assert property (@(posedge clock) disable iff (!rstn) // RULE9
    branch_taken |=> !loop_taken)
    else $error("loop back taken over a branch");
  AST_NO_END_PULSE: assert property (@(posedge clock) disable iff (!rstn) // RULE7
    !at_end |=> !loop_end_hit && !loop_taken)
    else $error("end pulse without last instruction");
  AST_SEQ_IDLE: assert property (@(posedge clock) disable iff (!rstn) // RULE18
    (!branch_taken && !at_end) |=> next_fetch_pc == $past(seq_next_pc))
    else $error("fetch left sequential order");
  AST_COUNT_HOLD: assert property (@(posedge clock) disable iff (!rstn) // RULE7
    (!at_end && !count_we) |=> count_r == $past(count_r))
    else $error("counter moved without cause");

  // last-pass, wrap and branch-at-end checks
  AST_LAST_PASS: assert property (@(posedge clock) disable iff (!rstn) // RULE18
    (at_end && count_r == 32'h00000001 && !branch_taken)
      |=> !loop_taken && count_r == 32'h00000000)
    else $error("last pass did not exit");
  AST_COUNT_WRAP: assert property (@(posedge clock) disable iff (!rstn) // RULE18
    (at_end && count_r == 32'h00000000) |=> !loop_taken && count_r == 32'hFFFFFFFF)
    else $error("zero count did not exit");
  AST_BRANCH_AT_END: assert property (@(posedge clock) disable iff (!rstn) // RULE13
    (at_end && branch_taken)
      |=> loop_end_hit && count_r == $past(count_r) - 32'h00000001)
    else $error("branch at end skipped the decrement");

  // loop register file and read port checks
  AST_REGS_HOLD: assert property (@(posedge clock) disable iff (!rstn) // RULE16
    (!rif.setup_we && !rif.aux_we)
      |=> $stable(rif.first_addr) && $stable(rif.stop_addr))
    else $error("loop registers changed with no write");
  AST_DIRECT_FIRST: assert property (@(posedge clock) disable iff (!rstn) // RULE3
    (rif.aux_we && !rif.setup_we && aux_addr == zolc_pkg::AUX_LOOP_FIRST)
      |=> rif.first_addr == $past(aux_wdata))
    else $error("direct start write ignored");
  AST_AUX_READ_STOP: assert property (@(posedge clock) disable iff (!rstn) // RULE16
    (aux_re && aux_addr == zolc_pkg::AUX_LOOP_STOP) |=> aux_rdata == $past(rif.stop_addr))
    else $error("end register read wrong");
  AST_AUX_READ_ZERO: assert property (@(posedge clock) disable iff (!rstn) // RULE16
    (aux_re && aux_addr != zolc_pkg::AUX_LOOP_FIRST && aux_addr != zolc_pkg::AUX_LOOP_STOP)
      |=> aux_rdata == 32'h00000000)
    else $error("unmapped read not zero");
  AST_RDATA_HOLD: assert property (@(posedge clock) disable iff (!rstn) // RULE16
    !aux_re |=> $stable(aux_rdata))
    else $error("read data moved without a read");
endmodule

// File: tb/zolc_prog_model.sv
// instruction-stream model: sequential address after each completing instruction
module zolc_prog_model (
  input  wire logic [31:0] current_program_counter,
  input  wire logic        has_limm,
  output logic      [31:0] seq_next_pc
);
  timeunit 1ns;
  timeprecision 1ps;
  // stream has no delayed or halting ops
  assign seq_next_pc = current_program_counter + (has_limm ? 32'h8 : 32'h4);
endmodule

// File: tb/zero_overhead_loop_ctrl_tb.sv
// self-checking bench for the zero-overhead loop controller
module zero_overhead_loop_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock = 1'b0, rstn = 1'b0, step = 1'b0, limm = 1'b0, br = 1'b0;
  logic        sx = 1'b0, aw = 1'b0, ar = 1'b0, cw = 1'b0, lt, lh;
  logic [11:0] aa = 12'h0;
  logic [31:0] pc = 32'h0, seq, tgt = 32'h0, disp = 32'h0, wd = 32'h0, cwd = 32'h0;
  logic [31:0] nfp, rd, cnt, e_nfp, r, v;
  logic [31:0] s_first = zolc_pkg::LOOP_FIRST_RST, s_stop = zolc_pkg::LOOP_STOP_RST;
  logic [31:0] s_cnt = zolc_pkg::ITER_CNT_RST;
  int          error_cnt = 0, checks_done = 0, cyc = 0, seed = 32'h35DFE0C5;
  logic [31:0] p_sel;
  logic [5:0]  ctl;
  int          pad_left = 0;

  zolc_prog_model prog (.current_program_counter(pc), .has_limm(limm), .seq_next_pc(seq));
  zolc_ctrl dut (.clock(clock), .rstn(rstn), .step(step), .current_program_counter(pc),
    .seq_next_pc(seq), .branch_taken(br), .branch_target(tgt), .setup_exec(sx),
    .setup_disp(disp), .aux_we(aw), .aux_addr(aa), .aux_wdata(wd), .aux_re(ar),
    .count_we(cw), .count_wdata(cwd), .next_fetch_pc(nfp), .loop_taken(lt),
    .loop_end_hit(lh), .aux_rdata(rd), .loop_iteration_counter(cnt));

  always #5 clock = ~clock;
  // hang guard: the run needs well under a thousand cycles
  always @(posedge clock) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      end_sim();
    end
  end

  task automatic end_sim();
    if (error_cnt == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    checks_done++;
    if (s !== e) begin
      $display("Error %s expected %h seen %h", n, e, s);
      error_cnt++;
    end
  endtask

  // loop-back decision from the rules: at end, no taken branch, count above 1
  function automatic logic loops_back(input logic h, input logic b, input logic [31:0] n);
    return h && !b && (n > 32'h00000001);
  endfunction

  // one completing instruction at p, flags c = {br, sx, aw, ar, cw, limm};
  // flags are set once here so no strobe is written twice in one step
  task automatic op(input logic [31:0] p, input logic [5:0] c);
    logic        hit, lb;
    logic [31:0] e_rd;
    {br, sx, aw, ar, cw, limm} = c;
    pc = p;
    step = 1'b1;
    #1;
    hit = (p === s_stop);
    lb = loops_back(hit, br, s_cnt);
    e_nfp = br ? tgt : (lb ? s_first : seq);
    e_rd = (aa == zolc_pkg::AUX_LOOP_STOP) ? s_stop : 32'h0;
    if (aa == zolc_pkg::AUX_LOOP_FIRST) e_rd = s_first;
    // setup beats a same-cycle aux write
    if (sx) begin
      s_stop = (p & zolc_pkg::WORD_ALIGN_MASK) + disp;
      s_first = seq;
    end else if (aw && aa == zolc_pkg::AUX_LOOP_FIRST) s_first = wd;
    else if (aw && aa == zolc_pkg::AUX_LOOP_STOP) s_stop = wd;
    s_cnt = hit ? s_cnt - 32'h1 : (cw ? cwd : s_cnt);
    @(negedge clock);
    chk("next_fetch_pc", e_nfp, nfp);
    chk("loop_taken", {31'h0, lb}, {31'h0, lt});
    chk("loop_end_hit", {31'h0, hit}, {31'h0, lh});
    chk("loop_iteration_counter", s_cnt, cnt);
    if (ar) chk("aux_rdata", e_rd, rd);
  endtask

  // reads start, stop and an unmapped place; also pads three words after writes
  task automatic rd_all();
    for (int a = 2; a < 5; a++) begin
      aa = a[11:0];
      op(32'h200, 6'h04);
    end
  endtask

  initial begin
    repeat (10) @(posedge clock);
    @(negedge clock);
    rstn = 1'b1;
    // one-word loop at 0x100 made by direct writes
    for (int a = 2; a < 4; a++) begin
      aa = a[11:0];
      wd = 32'h100;
      op(32'h204, 6'h08);
    end
    rd_all();
    cwd = 32'h3;
    op(32'h20C, 6'h02);
    e_nfp = 32'h100;
    repeat (6) op(e_nfp, 6'h00);
    op(32'h100, 6'h00);
    tgt = 32'h400;
    op(32'h100, 6'h20);
    cwd = 32'h7;
    op(32'h100, 6'h02);
    // setup and an aux write in one cycle; the setup must win
    {aa, wd, disp} = {12'h002, 32'h5A5A5A5A, 32'h00000040};
    op(32'h302, 6'h19);
    rd_all();
    // random traffic; addresses stay word aligned
    repeat (300) begin
      r = $random(seed);
      v = $random(seed) & zolc_pkg::WORD_ALIGN_MASK;
      // setup bodies span at least two words
      {aa, cwd, tgt, wd, disp} = {10'h0, r[17:16], 30'h0, r[7:6], v, v, 24'h0, v[7:0] | 8'h10};
      ctl = {r[3:1] == 0, r[11:8] == 0, r[14:12] == 0, r[15], r[5:4] == 0, r[0]};
      if (ctl[4] || ctl[3]) ctl[2] = 1'b0;
      p_sel = r[19] ? (r[18] ? s_stop : e_nfp) : v;
      // three words pass between a direct write and the loop end
      if (pad_left > 0) p_sel = v;
      // no long-immediate opcode in the final slot
      if (p_sel === s_stop) ctl[0] = 1'b0;
      op(p_sel, ctl);
      pad_left = ctl[3] ? 3 : (pad_left > 0 ? pad_left - 1 : 0);
    end
    // mid-run reset: outputs and loop state go back to reset values
    rstn = 1'b0;
    @(negedge clock);
    chk("reset next_fetch_pc", 32'h00000000, nfp);
    chk("reset loop_taken", 32'h00000000, {31'h0, lt});
    chk("reset loop_end_hit", 32'h00000000, {31'h0, lh});
    chk("reset loop_iteration_counter", zolc_pkg::ITER_CNT_RST, cnt);
    chk("reset aux_rdata", 32'h00000000, rd);
    rstn = 1'b1;
    s_first = zolc_pkg::LOOP_FIRST_RST;
    s_stop = zolc_pkg::LOOP_STOP_RST;
    s_cnt = zolc_pkg::ITER_CNT_RST;
    rd_all();
    end_sim();
  end
endmodule
